// ---- core/sfe_spi_front.sv ----
`default_nettype none
module sfe_spi_front #(
  parameter int unsigned ADDR_W   = 24,
  parameter int unsigned OP_TICKS = 1000
) (
  input  wire logic              ref_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              sck_i,
  input  wire logic              cs_n_i,
  input  wire logic              hold_n_i,
  input  wire logic              wp_n_i,
  input  wire logic              dio0_i,
  input  wire logic [7:0]        array_byte_i,
  output logic                   dio0_o,
  output logic                   dio0_oe_o,
  output logic                   so_o,
  output logic                   so_oe_o,
  output logic [ADDR_W-1:0]      array_addr_o,
  output logic                   op_start_o,
  output logic [1:0]             op_kind_o,
  output logic                   busy_o
);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  logic       sck_s;
  logic       cs_s;
  logic       hold_s;
  logic       wp_s;
  logic       din_s;

  sfe_sync #(
    .W       (5),
    .RST_VAL (sfe_pkg::PINS_IDLE)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .d_i       ({dio0_i, wp_n_i, hold_n_i, cs_n_i, sck_i}),
    .q_o       (pins_s)
  );

  assign sck_s  = pins_s[0];
  assign cs_s   = pins_s[1];
  assign hold_s = pins_s[2];
  assign wp_s   = pins_s[3];
  assign din_s  = pins_s[4];

  logic sck_prev_r;
  logic cs_prev_r;
  logic armed_r;
  logic paused_r;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sck_prev_r <= 1'b0;
      cs_prev_r  <= 1'b1;
    end else begin
      sck_prev_r <= sck_s;
      cs_prev_r  <= cs_s;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      armed_r <= 1'b0;
    end else if (cs_s) begin
      armed_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pause control
  // ----------------------------------------------------------------
  // levels suffice: both the edge case and the late case reduce to
  // pause level plus clock low
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      paused_r <= 1'b0;
    end else if (cs_s) begin
      paused_r <= 1'b0;
    end else if (!paused_r && !hold_s && !sck_s) begin
      paused_r <= 1'b1;
    end else if (paused_r && hold_s && !sck_s) begin
      paused_r <= 1'b0;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;

  // mode 0 and 3 share edges
  assign sck_rise = sck_s & ~sck_prev_r & ~cs_s & ~paused_r & armed_r;
  assign sck_fall = ~sck_s & sck_prev_r & ~cs_s & ~paused_r & armed_r;
  assign cs_rise  = cs_s & ~cs_prev_r;

  // ----------------------------------------------------------------
  // frame bit and byte counting
  // ----------------------------------------------------------------
  logic [2:0] bit_cnt_r;
  logic [3:0] byte_cnt_r;
  logic [7:0] in_sh_r;
  logic [7:0] new_byte;
  logic       byte_done;

  assign new_byte  = {in_sh_r[6:0], din_s};
  assign byte_done = sck_rise & (bit_cnt_r == sfe_pkg::BIT_LAST);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || cs_s) begin
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 4'h0;
      in_sh_r    <= 8'h00;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      in_sh_r   <= new_byte;
      if (byte_done && byte_cnt_r != sfe_pkg::BYTES_MAX) begin
        byte_cnt_r <= byte_cnt_r + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // command sequencing
  // ----------------------------------------------------------------
  sfe_pkg::sfe_state_e state_r;
  sfe_pkg::sfe_state_e state_nxt;
  logic [7:0]          opcode_r;

  always_comb begin
    state_nxt = state_r;
    if (byte_done) begin
      case (state_r)
        sfe_pkg::ST_CMD: begin
          case (new_byte)
            sfe_pkg::CMD_STATUS_READ:  state_nxt = sfe_pkg::ST_STAT;
            sfe_pkg::CMD_DUAL_READ:    state_nxt = sfe_pkg::ST_ADDR;
            sfe_pkg::CMD_PAGE_PROG:    state_nxt = sfe_pkg::ST_ADDR;
            sfe_pkg::CMD_SECTOR_ERASE: state_nxt = sfe_pkg::ST_ADDR;
            sfe_pkg::CMD_STATUS_WRITE: state_nxt = sfe_pkg::ST_WDATA;
            default:                   state_nxt = sfe_pkg::ST_IGN;
          endcase
        end
        sfe_pkg::ST_ADDR: begin
          if (byte_cnt_r == sfe_pkg::IDX_LAST_ADDR) begin
            if (opcode_r == sfe_pkg::CMD_DUAL_READ) begin
              state_nxt = sfe_pkg::ST_DUMMY;
            end else begin
              state_nxt = sfe_pkg::ST_WDATA;
            end
          end
        end
        sfe_pkg::ST_DUMMY: begin
          if (byte_cnt_r == sfe_pkg::IDX_LAST_DUMMY) begin
            state_nxt = sfe_pkg::ST_DUAL;
          end
        end
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || cs_s) begin
      state_r <= sfe_pkg::ST_CMD;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || cs_s) begin
      opcode_r <= sfe_pkg::CMD_NONE;
    end else if (byte_done && state_r == sfe_pkg::ST_CMD) begin
      opcode_r <= new_byte;
    end
  end

  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        wdata_r;
  logic              dual_load;

  assign dual_load = sck_rise && state_nxt == sfe_pkg::ST_DUAL &&
                     bit_cnt_r[1:0] == sfe_pkg::DUAL_LAST;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      addr_r <= '0;
    end else if (byte_done && state_r == sfe_pkg::ST_ADDR) begin
      addr_r <= {addr_r[ADDR_W-9:0], new_byte};
    end else if (dual_load) begin
      addr_r <= addr_r + ADDR_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wdata_r <= 8'h00;
    end else if (byte_done && state_r == sfe_pkg::ST_WDATA &&
                 byte_cnt_r == sfe_pkg::IDX_WDATA) begin
      wdata_r <= new_byte;
    end
  end

  // ----------------------------------------------------------------
  // status and execution at deselect
  // ----------------------------------------------------------------
  logic       wlatch_r;
  logic [3:0] bp_r;
  logic       lock_r;
  logic       busy;
  logic       op_done;
  logic [7:0] status_byte;
  logic       go_ok;
  logic       set_x;
  logic       clr_x;
  logic       wrsr_x;
  logic       pp_x;
  logic       se_x;
  logic       ce_x;
  logic       op_go;

  assign status_byte = {lock_r, sfe_pkg::RSV_VALUE, bp_r, wlatch_r, busy};

  assign go_ok = cs_rise & armed_r & ~paused_r & ~busy &
                 (bit_cnt_r == 3'h0);
  assign set_x = go_ok & (opcode_r == sfe_pkg::CMD_WRITE_LATCH_SET) &
                 (byte_cnt_r >= sfe_pkg::LEN_ONE);
  assign clr_x = go_ok & (opcode_r == sfe_pkg::CMD_WRITE_LATCH_CLEAR) &
                 (byte_cnt_r >= sfe_pkg::LEN_ONE);
  assign wrsr_x = go_ok & wlatch_r & ~(lock_r & ~wp_s) &
                  (opcode_r == sfe_pkg::CMD_STATUS_WRITE) &
                  (byte_cnt_r >= sfe_pkg::LEN_WRSR);
  assign pp_x = go_ok & wlatch_r & ~|bp_r &
                (opcode_r == sfe_pkg::CMD_PAGE_PROG) &
                (byte_cnt_r >= sfe_pkg::LEN_PP);
  assign se_x = go_ok & wlatch_r & ~|bp_r &
                (opcode_r == sfe_pkg::CMD_SECTOR_ERASE) &
                (byte_cnt_r >= sfe_pkg::LEN_SE);
  assign ce_x = go_ok & wlatch_r & ~|bp_r &
                (opcode_r == sfe_pkg::CMD_CHIP_ERASE) &
                (byte_cnt_r >= sfe_pkg::LEN_ONE);
  assign op_go = wrsr_x | pp_x | se_x | ce_x;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wlatch_r <= 1'b0;
    end else if (set_x) begin
      wlatch_r <= 1'b1;
    end else if (clr_x || op_done) begin
      wlatch_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      bp_r   <= sfe_pkg::BP_RESET;
      lock_r <= sfe_pkg::LOCK_RESET;
    end else if (wrsr_x) begin
      bp_r   <= wdata_r[sfe_pkg::BIT_BP_HI:sfe_pkg::BIT_BP_LO];
      lock_r <= wdata_r[sfe_pkg::BIT_LOCK];
    end
  end

  logic       op_start_r;
  logic [1:0] op_kind_r;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      op_start_r <= 1'b0;
      op_kind_r  <= sfe_pkg::OPK_STATUS;
    end else begin
      op_start_r <= op_go;
      if (pp_x) begin
        op_kind_r <= sfe_pkg::OPK_PROG;
      end else if (se_x) begin
        op_kind_r <= sfe_pkg::OPK_SECTOR;
      end else if (ce_x) begin
        op_kind_r <= sfe_pkg::OPK_CHIP;
      end else if (wrsr_x) begin
        op_kind_r <= sfe_pkg::OPK_STATUS;
      end
    end
  end

  sfe_op_timer #(
    .TICKS (OP_TICKS)
  ) u_timer (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (op_go),
    .busy_o    (busy),
    .done_o    (op_done)
  );

  // ----------------------------------------------------------------
  // output shifting
  // ----------------------------------------------------------------
  logic [7:0] out_sh_r;
  logic       so_r;
  logic       dio_r;
  logic       so_oe_r;
  logic       dio_oe_r;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || cs_s) begin
      out_sh_r <= 8'h00;
      so_r     <= 1'b0;
      dio_r    <= 1'b0;
    // fresh status each byte so polling sees busy drop
    end else if (byte_done && state_nxt == sfe_pkg::ST_STAT) begin
      out_sh_r <= status_byte;
    end else if (dual_load) begin
      out_sh_r <= array_byte_i;
    end else if (sck_fall && state_r == sfe_pkg::ST_STAT) begin
      so_r     <= out_sh_r[7];
      out_sh_r <= {out_sh_r[6:0], 1'b0};
    end else if (sck_fall && state_r == sfe_pkg::ST_DUAL) begin
      so_r     <= out_sh_r[7];
      dio_r    <= out_sh_r[6];
      out_sh_r <= {out_sh_r[5:0], 2'h0};
    end
  end

  // data line drives in dual only
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      so_oe_r  <= 1'b0;
      dio_oe_r <= 1'b0;
    end else begin
      so_oe_r  <= ~cs_s & ~paused_r & (state_r == sfe_pkg::ST_STAT ||
                                       state_r == sfe_pkg::ST_DUAL);
      dio_oe_r <= ~cs_s & ~paused_r & (state_r == sfe_pkg::ST_DUAL);
    end
  end

  assign so_o         = so_r;
  assign so_oe_o      = so_oe_r;
  assign dio0_o       = dio_r;
  assign dio0_oe_o    = dio_oe_r;
  assign array_addr_o = addr_r;
  assign op_start_o   = op_start_r;
  assign op_kind_o    = op_kind_r;
  assign busy_o       = busy;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_deselect_hiz: assert property (
    cs_s |=> !so_oe_o && !dio0_oe_o)
    else $error("output driven while deselected");

  chk_pause_hiz: assert property (
    paused_r ##1 paused_r |-> !so_oe_o && !dio0_oe_o)
    else $error("output driven while paused");

  chk_pause_entry: assert property (
    !cs_s && !paused_r && !hold_s && !sck_s |=> paused_r)
    else $error("pause not entered with clock low");

  chk_pause_exit: assert property (
    !cs_s && paused_r && hold_s && !sck_s |=> !paused_r)
    else $error("pause not left with clock low");

  chk_pause_wait: assert property (
    !paused_r && sck_s |=> !paused_r)
    else $error("pause entered with clock high");

  chk_latch_set: assert property (
    set_x |=> wlatch_r ##1 wlatch_r)
    else $error("latch not set by set command");

  chk_latch_done: assert property (
    op_done |=> !wlatch_r)
    else $error("latch not cleared at completion");

  chk_status_guard: assert property (
    bp_r != $past(bp_r) |-> $past(wlatch_r) &&
      !($past(lock_r) && !$past(wp_s)))
    else $error("status written without permission");

  chk_busy_follows: assert property (
    op_go |=> busy ##1 busy)
    else $error("busy not raised by operation");

  chk_dual_only: assert property (
    dio0_oe_o |-> $past(state_r) == sfe_pkg::ST_DUAL)
    else $error("data line driven outside dual read");

  chk_rsv_zero: assert property (
    byte_done && state_nxt == sfe_pkg::ST_STAT |=>
      out_sh_r[sfe_pkg::BIT_RSV] == 1'b0)
    else $error("reserved status bit not zero");

  cov_pause: cover property (!paused_r ##1 paused_r ##[1:50] !paused_r);
  cov_dual: cover property (dual_load ##[1:200] dual_load);
  cov_wrsr: cover property (wrsr_x);
  cov_stat: cover property (byte_done && state_nxt == sfe_pkg::ST_STAT);

endmodule
`default_nettype wire

// ---- core/sfe_pkg.sv ----
`default_nettype none
package sfe_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_LATCH_SET   = 8'h06;
  localparam logic [7:0] CMD_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ       = 8'h05;
  localparam logic [7:0] CMD_DUAL_READ         = 8'h3B;
  localparam logic [7:0] CMD_STATUS_WRITE      = 8'h01;
  localparam logic [7:0] CMD_PAGE_PROG         = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE      = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE        = 8'hC7;
  localparam logic [7:0] CMD_NONE              = 8'h00;

  // ----------------------------------------------------------------
  // status byte layout
  // ----------------------------------------------------------------
  localparam int unsigned BIT_BUSY   = 0;
  localparam int unsigned BIT_WLATCH = 1;
  localparam int unsigned BIT_BP_LO  = 2;
  localparam int unsigned BIT_BP_HI  = 5;
  localparam int unsigned BIT_RSV    = 6;
  localparam int unsigned BIT_LOCK   = 7;
  localparam logic [3:0]  BP_RESET   = 4'h0;
  localparam logic        LOCK_RESET = 1'b0;
  localparam logic        RSV_VALUE  = 1'b0;

  // ----------------------------------------------------------------
  // frame byte indices and least lengths in whole bytes
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_LAST_ADDR  = 4'h3;
  localparam logic [3:0] IDX_LAST_DUMMY = 4'h4;
  localparam logic [3:0] IDX_WDATA      = 4'h1;
  localparam logic [3:0] BYTES_MAX      = 4'hF;
  localparam logic [3:0] LEN_ONE        = 4'h1;
  localparam logic [3:0] LEN_WRSR       = 4'h2;
  localparam logic [3:0] LEN_SE         = 4'h4;
  localparam logic [3:0] LEN_PP         = 4'h5;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [1:0] DUAL_LAST      = 2'h3;

  // ----------------------------------------------------------------
  // internal operation kinds and pin reset levels
  // ----------------------------------------------------------------
  localparam logic [1:0] OPK_STATUS = 2'h0;
  localparam logic [1:0] OPK_PROG   = 2'h1;
  localparam logic [1:0] OPK_SECTOR = 2'h2;
  localparam logic [1:0] OPK_CHIP   = 2'h3;
  // {dio0, wp_n, hold_n, cs_n, sck}: idle, deselected
  localparam logic [4:0] PINS_IDLE  = 5'h0E;

  typedef enum logic [2:0] {
    ST_CMD   = 3'h0,
    ST_ADDR  = 3'h1,
    ST_DUMMY = 3'h3,
    ST_DUAL  = 3'h2,
    ST_STAT  = 3'h6,
    ST_WDATA = 3'h7,
    ST_IGN   = 3'h5
  } sfe_state_e;

endpackage
`default_nettype wire

// ---- core/sfe_sync.sv ----
`default_nettype none
module sfe_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // only q_r reads meta_r
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      meta_r <= RST_VAL;
      q_r    <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule
`default_nettype wire

// ---- core/sfe_op_timer.sv ----
`default_nettype none
module sfe_op_timer #(
  parameter int unsigned TICKS = 1000
) (
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);
  localparam int unsigned CW = $clog2(TICKS + 1);
  localparam logic [CW-1:0] LOAD = CW'(TICKS - 1);
  localparam logic [CW-1:0] ZERO = '0;

  logic [CW-1:0] cnt_r;
  logic          busy_r;
  logic          done_r;

  // runs on its own; only reset can stop it once started
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cnt_r  <= ZERO;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start_i && !busy_r) begin
        busy_r <= 1'b1;
        cnt_r  <= LOAD;
      end else if (busy_r) begin
        if (cnt_r == ZERO) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - CW'(1);
        end
      end
    end
  end

  assign busy_o = busy_r;
  assign done_o = done_r;
endmodule
`default_nettype wire

// ---- verif/sfe_host_model.sv ----
`default_nettype none
module sfe_host_model (
  input  wire logic ref_clk_i,
  input  wire logic so_i,
  input  wire logic io_i,
  input  wire logic oe_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      hold_n_o,
  output logic      d_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cpol = 1'b0;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    hold_n_o = 1'b1;
    d_o = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // ----------------------------------------------------------------
  // one frame, half sck period is 8 ref cycles
  // ----------------------------------------------------------------
  // mode idle, msb first, pause
  task automatic frame(input int nb, input logic [63:0] tx, input int ha,
                       output logic [63:0] rs, output logic [63:0] ri,
                       output logic oe_h);
    rs = '0;
    ri = '0;
    oe_h = 1'b1;
    @(posedge ref_clk_i);
    // idle level settles first, so a mode change never looks like a rise
    sck_o <= cpol;
    hw(8);
    cs_n_o <= 1'b0;
    hw(8);
    for (int k = 0; k < nb; k++) begin
      sck_o <= 1'b0;
      d_o <= tx[nb-1-k];
      hw(8);
      rs = {rs[62:0], so_i};
      ri = {ri[62:0], io_i};
      if (k == ha) begin
        hold_n_o <= 1'b0;
        hw(10);
        oe_h = oe_i;
        // clock pulse while paused must be ignored
        sck_o <= 1'b1;
        hw(8);
        sck_o <= 1'b0;
        hw(8);
        hold_n_o <= 1'b1;
        hw(8);
      end
      sck_o <= 1'b1;
      hw(8);
    end
    sck_o <= cpol;
    hw(8);
    cs_n_o <= 1'b1;
    d_o <= ~d_o;
    hw(8);
  endtask
endmodule
`default_nettype wire

// ---- verif/serial_flash_spi_front_end_bench.sv ----
`default_nettype none
module serial_flash_spi_front_end_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 20;
  logic        clk = 1'b0;
  logic        resetn_i = 1'b0;
  logic        wp_n = 1'b1;
  logic        sck, cs_n, hold_n, hd, io_w, so_w;
  logic        dio0, dio0_oe, so, so_oe, op_start, busy;
  logic [1:0]  op_kind;
  logic [23:0] addr;
  logic [7:0]  abyte;
  int          failures = 0;
  int          check_count = 0;
  int          starts = 0;
  int          m_starts = 0;
  logic        m_wel = 1'b0;
  logic        m_lock = 1'b0;
  logic [3:0]  m_bp = 4'h0;
  logic [1:0]  m_kind = 2'h0;
  logic [63:0] rso, rio;
  logic        oeh;
  logic [7:0]  cop [3] = '{8'h02, 8'h20, 8'hC7};
  int          clen [3] = '{40, 32, 8};

  // array stand-in, a pure function of the address
  assign abyte = addr[7:0] ^ 8'h5A;
  assign io_w = dio0_oe ? dio0 : hd;
  // released output shows a changing pattern, not a stale bit
  assign so_w = so_oe ? so : ~hd;

  initial forever #5 clk = ~clk;
  always @(posedge clk) if (op_start === 1'b1) starts++;

  sfe_spi_front #(.OP_TICKS(TK)) DUT (
    .ref_clk_i(clk), .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n),
    .hold_n_i(hold_n), .wp_n_i(wp_n), .dio0_i(io_w),
    .array_byte_i(abyte), .dio0_o(dio0), .dio0_oe_o(dio0_oe),
    .so_o(so), .so_oe_o(so_oe), .array_addr_o(addr),
    .op_start_o(op_start), .op_kind_o(op_kind), .busy_o(busy));
  sfe_host_model host (
    .ref_clk_i(clk), .so_i(so_w), .io_i(io_w), .oe_i(so_oe),
    .sck_o(sck), .cs_n_o(cs_n), .hold_n_o(hold_n), .d_o(hd));

  // ----------------------------------------------------------------
  // checking and model
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] s, e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic stat(input int h);
    logic [7:0] st;
    st = {m_lock, 1'b0, m_bp, m_wel, 1'b0};
    host.frame(24, 64'h050000, h, rso, rio, oeh);
    chk("status", rso[15:0], {st, st});
    if (h >= 0) chk("pause_oe", oeh, 1'b0);
  endtask
  task automatic run(input int nb, input logic [63:0] tx);
    logic [7:0] op;
    logic ok, f;
    op = tx[nb-1 -: 8];
    f = 1'b0;
    host.frame(nb, tx, -1, rso, rio, oeh);
    ok = (nb % 8 == 0) && m_wel;
    if (nb == 8 && op == sfe_pkg::CMD_WRITE_LATCH_SET) m_wel = 1'b1;
    if (nb == 8 && op == sfe_pkg::CMD_WRITE_LATCH_CLEAR) m_wel = 1'b0;
    if (op == sfe_pkg::CMD_STATUS_WRITE && ok && nb >= 16
        && !(m_lock && !wp_n)) begin
      m_bp = tx[nb-11 -: 4];
      m_lock = tx[nb-9];
      m_kind = 2'h0;
      f = 1'b1;
    end
    for (int i = 0; i < 3; i++)
      if (op == cop[i] && ok && m_bp == 4'h0 && nb >= clen[i]) begin
        m_kind = 2'(i + 1);
        f = 1'b1;
      end
    if (f) m_starts++;
    if (f) m_wel = 1'b0;
    chk("busy", busy, f);
    repeat (30) @(posedge clk);
    chk("busy_end", busy, 1'b0);
    chk("starts", starts, m_starts);
    chk("kind", op_kind, m_kind);
    if (f && (m_kind == 2'h1 || m_kind == 2'h2))
      chk("addr", addr, tx[nb-9 -: 24]);
    stat(-1);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [63:0] tx;
    logic [23:0] a;
    logic [7:0]  b0, b1, es, ei;
    void'($urandom(2));
    repeat (5) @(posedge clk);
    resetn_i <= 1'b1;
    repeat (8) @(posedge clk);
    stat(-1);
    for (int m = 0; m < 2; m++) begin
      host.cpol = m[0];
      run(8, 64'h06);
      run(8, 64'h04);
    end
    run(8, 64'h06);
    run(17, 64'h00200);
    run(16, 64'h0184 | 64'($urandom & 32'h38));
    for (int i = 0; i < 3; i++) begin
      run(8, 64'h06);
      run(clen[i], 64'(cop[i]) << (clen[i] - 8));
    end
    wp_n <= 1'b0;
    run(16, 64'h0100);
    wp_n <= 1'b1;
    run(16, 64'h0100);
    for (int i = 0; i < 3; i++) begin
      run(8, 64'h06);
      tx = (64'($urandom) << 32) | 64'($urandom);
      tx = tx & ((64'h1 << (clen[i] - 8)) - 64'h1);
      run(clen[i], (64'(cop[i]) << (clen[i] - 8)) | tx);
    end
    wp_n <= 1'b0;
    a = 24'($urandom);
    b0 = a[7:0] ^ 8'h5A;
    b1 = 8'(a + 24'h1) ^ 8'h5A;
    for (int j = 0; j < 8; j++) begin
      es[7-j] = (j < 4) ? b0[7-2*j] : b1[7-2*(j-4)];
      ei[7-j] = (j < 4) ? b0[6-2*j] : b1[6-2*(j-4)];
    end
    host.frame(48, {16'h0, 8'h3B, a, 8'h00, 8'hAA}, -1, rso, rio, oeh);
    chk("dual_so", rso[7:0], es);
    chk("dual_io", rio[7:0], ei);
    wp_n <= 1'b1;
    stat(12);
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
